// ===== hdl/pic_comp_fields.sv
`timescale 1ns/1ns
module pic_comp_fields (
  // compensation word in force
  input  wire logic [pic_pkg::COMP_W-1:0] comp,
  // decoded loop selections
  output pic_pkg::pic_comp_s               fld
);
  import pic_pkg::*;

  // split fields join the low-position part over the high-position part
  always_comb begin
    fld.iloop_int_cap_code    = {comp[CZI_LO_POS +: 2],
                                 comp[CZI_HI_POS +: 2]};
    fld.iloop_filter_cap_code = comp[CPI_POS +: 5];
    fld.iloop_int_cap_doubler = comp[MUL_POS];
    fld.iloop_gain_res_code   = comp[RVI_POS +: 6];
    fld.vloop_int_cap_code    = {comp[CZV_LO_POS +: 2],
                                 comp[CZV_HI_POS +: 2]};
    fld.vloop_filter_cap_code = comp[CPV_POS +: 5];
    fld.vloop_gain_res_code   = comp[RVV_POS +: 6];
    fld.vloop_transcond_code  = comp[GMV_POS +: 2];
    fld.iloop_transcond_code  = comp[GMI_POS +: 2];
  end

endmodule

// ===== hdl/pic_ident_comp_regs.sv
`timescale 1ns/1ns
module pic_ident_comp_regs #(
  parameter logic [47:0] PART_CODE = 48'h0a0b0c0d0e0f, // arbitrary value
  parameter logic [3:0]  SIREV_MAJ = 4'h1,             // arbitrary value
  parameter logic [3:0]  SIREV_MIN = 4'h0,             // arbitrary value
  parameter logic [7:0]  SIREV_SUB = 8'h00,            // arbitrary value
  parameter int          SUM_W     = 16
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // command port from the shared command decoder
  input  wire pic_pkg::pic_req_s           req,
  output pic_pkg::pic_resp_s               resp,
  // communication fault set pulses toward shared status
  output pic_pkg::pic_fault_s              fault,
  // nonvolatile image load (power-up and restore)
  input  wire logic                        nvm_load,
  input  wire pic_pkg::pic_image_s         nvm_image,
  input  wire logic [pic_pkg::COMP_W-1:0]  pin_comp,
  input  wire logic                        strap_override_comp,
  // image handed to the shared store logic, with its sum
  output pic_pkg::pic_image_s              store_image,
  output logic [SUM_W-1:0]                 stored_image_sum,
  // loop hardware
  input  wire logic                        conv_en,
  output pic_pkg::pic_comp_s               loop_comp
);
  import pic_pkg::*;

  initial begin
    if (SUM_W < 8 || SUM_W > 32)
      $error("pic_ident_comp_regs: SUM_W must lie in 8..32");
  end

  // whole module state
  typedef struct packed {
    pic_phase_e        phase;
    logic [ID_W-1:0]   maker;
    logic [ID_W-1:0]   model;
    logic [ID_W-1:0]   revn;
    logic [ID_W-1:0]   serial;
    logic [COMP_W-1:0] comp;
    logic [COMP_W-1:0] comp_hw;
    pic_resp_s         resp;
    pic_fault_s        fault;
    logic [SUM_W-1:0]  sum;
  } pic_state_s;

  pic_state_s state;
  pic_state_s next_state;

  pic_image_s       cur_image;
  logic [SUM_W-1:0] cur_sum;

  // block length of a code; zero means not served here
  function automatic logic [CNT_W-1:0] cmd_len(input logic [7:0] code);
    case (code)
      CMD_MAKER, CMD_MODEL,
      CMD_REVN, CMD_SERIAL: cmd_len = LEN_ID;
      CMD_PART:             cmd_len = LEN_PART;
      CMD_SIREV:            cmd_len = LEN_SIREV;
      CMD_COMP:             cmd_len = LEN_COMP;
      default:              cmd_len = LEN_NONE;
    endcase
  endfunction

  // codes that take no write
  function automatic logic cmd_ro(input logic [7:0] code);
    cmd_ro = (code == CMD_PART) || (code == CMD_SIREV);
  endfunction

  // silicon revision word
  function automatic logic [REV_W-1:0] sirev_word();
    logic [REV_W-1:0] w;
    w = '0;
    w[SIREV_MAJ_POS +: 4] = SIREV_MAJ;
    w[SIREV_MIN_POS +: 4] = SIREV_MIN;
    w[SIREV_SUB_POS +: 8] = SIREV_SUB;
    return w;
  endfunction

  // image as it stands in the stores, handed out for the NVM store
  always_comb begin
    cur_image.maker  = state.maker;
    cur_image.model  = state.model;
    cur_image.revn   = state.revn;
    cur_image.serial = state.serial;
    cur_image.comp   = state.comp;
  end

  pic_image_sum #(
    .SUM_W (SUM_W)
  ) u_sum (
    .img (cur_image),
    .sum (cur_sum)
  );

  pic_comp_fields u_fields (
    .comp (state.comp_hw),
    .fld  (loop_comp)
  );

  // next state: load wins over a request in the same cycle, since a
  // half-loaded image must never be answered from
  always_comb begin
    logic [CNT_W-1:0] len;
    len                      = cmd_len(req.code);
    next_state               = state;
    next_state.resp          = '0;
    next_state.fault         = '0;
    next_state.sum           = cur_sum;

    if (nvm_load) begin
      next_state.phase  = PH_RUN;
      next_state.maker  = nvm_image.maker;
      next_state.model  = nvm_image.model;
      next_state.revn   = nvm_image.revn;
      next_state.serial = nvm_image.serial;
      // override set keeps the pin-detected compensation
      if (strap_override_comp) begin
        next_state.comp    = pin_comp;
        next_state.comp_hw = pin_comp;
      end else begin
        next_state.comp    = nvm_image.comp;
        next_state.comp_hw = nvm_image.comp;
      end
      if (req.valid) begin
        next_state.resp.valid   = 1'b1;
        next_state.resp.refused = 1'b1;
      end
    end else if (req.valid) begin
      next_state.resp.valid = 1'b1;
      case (state.phase)
        PH_BOOT: begin
          // stores hold no image yet
          next_state.resp.refused = 1'b1;
        end
        PH_RUN: begin
          if (len == LEN_NONE) begin
            next_state.resp.refused = 1'b1;
          end else if (req.write) begin
            if (cmd_ro(req.code)) begin
              // stores stay untouched
              next_state.resp.refused             = 1'b1;
              next_state.fault.status_byte_cml    = 1'b1;
              next_state.fault.status_cml[CML_IVC_BIT] = 1'b1;
            end else if (req.count != len) begin
              // wrong block length is bad data, not a bad command
              next_state.resp.refused             = 1'b1;
              next_state.fault.status_byte_cml    = 1'b1;
              next_state.fault.status_cml[CML_IVD_BIT] = 1'b1;
            end else begin
              case (req.code)
                CMD_MAKER:  next_state.maker  = req.data[ID_W-1:0];
                CMD_MODEL:  next_state.model  = req.data[ID_W-1:0];
                CMD_REVN:   next_state.revn   = req.data[ID_W-1:0];
                CMD_SERIAL: next_state.serial = req.data[ID_W-1:0];
                CMD_COMP: begin
                  // reserved bits kept as written; host keeps them zero
                  next_state.comp = req.data[COMP_W-1:0];
                  // while converting the loop keeps its old settings
                  if (!conv_en) begin
                    next_state.comp_hw = req.data[COMP_W-1:0];
                  end
                end
                default: next_state.resp.refused = 1'b1;
              endcase
            end
          end else begin
            next_state.resp.count = len;
            case (req.code)
              CMD_MAKER:  next_state.resp.data = DATA_W'(state.maker);
              CMD_MODEL:  next_state.resp.data = DATA_W'(state.model);
              CMD_REVN:   next_state.resp.data = DATA_W'(state.revn);
              CMD_SERIAL: next_state.resp.data = DATA_W'(state.serial);
              // byte 0 in the low lane goes out first
              CMD_PART:   next_state.resp.data = PART_CODE;
              CMD_SIREV:  next_state.resp.data = DATA_W'(sirev_word());
              CMD_COMP:   next_state.resp.data = DATA_W'(state.comp);
              default:    next_state.resp.data = '0;
            endcase
          end
        end
        default: begin
          next_state.phase        = PH_BOOT;
          next_state.resp.refused = 1'b1;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state.phase   <= PH_BOOT;
      state.maker   <= ID_RST;
      state.model   <= ID_RST;
      state.revn    <= ID_RST;
      state.serial  <= ID_RST;
      state.comp    <= COMP_RST;
      state.comp_hw <= COMP_RST;
      state.resp    <= '0;
      state.fault   <= '0;
      state.sum     <= '0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state register
  assign resp             = state.resp;
  assign fault            = state.fault;
  assign store_image      = cur_image;
  assign stored_image_sum = state.sum;

endmodule

// ===== hdl/pic_image_sum.sv
`timescale 1ns/1ns
module pic_image_sum #(
  parameter int SUM_W = 16
) (
  // image over which the sum runs
  input  wire pic_pkg::pic_image_s img,
  // byte sum
  output logic [SUM_W-1:0]         sum
);
  import pic_pkg::*;

  localparam int NBYTES = $bits(pic_image_s) / 8;

  initial begin
    if (SUM_W < 8 || SUM_W > 32)
      $error("pic_image_sum: SUM_W must lie in 8..32");
  end

  // plain byte sum; serial bytes are part of the image, so a serial change
  // moves the sum whenever it changes the total of its bytes
  always_comb begin
    sum = '0;
    for (int i = 0; i < NBYTES; i++) begin
      sum = sum + SUM_W'(img[i*8 +: 8]);
    end
  end

endmodule

// ===== hdl/pic_pkg.sv
package pic_pkg;

  // data widths of the stores and of the command data path
  localparam int ID_W   = 24;
  localparam int PART_W = 48;
  localparam int REV_W  = 16;
  localparam int COMP_W = 40;
  localparam int DATA_W = 48;
  localparam int CNT_W  = 3;

  // command codes served by this bank
  localparam logic [7:0] CMD_MAKER  = 8'h99;
  localparam logic [7:0] CMD_MODEL  = 8'h9a;
  localparam logic [7:0] CMD_REVN   = 8'h9b;
  localparam logic [7:0] CMD_SERIAL = 8'h9e;
  localparam logic [7:0] CMD_PART   = 8'had;
  localparam logic [7:0] CMD_SIREV  = 8'hae;
  localparam logic [7:0] CMD_COMP   = 8'hb1;

  // block byte counts
  localparam logic [2:0] LEN_NONE  = 3'h0;
  localparam logic [2:0] LEN_ID    = 3'h3;
  localparam logic [2:0] LEN_SIREV = 3'h2;
  localparam logic [2:0] LEN_COMP  = 3'h5;
  localparam logic [2:0] LEN_PART  = 3'h6;

  // values held before the first nonvolatile load
  localparam logic [23:0] ID_RST   = 24'h000000;
  localparam logic [39:0] COMP_RST = 40'h0000000000;

  // communication status bit positions
  localparam int CML_IVC_BIT = 7;
  localparam int CML_IVD_BIT = 6;

  // silicon revision field positions
  localparam int SIREV_MAJ_POS = 12;
  localparam int SIREV_MIN_POS = 8;
  localparam int SIREV_SUB_POS = 0;

  // compensation field positions
  localparam int CZI_LO_POS = 24;
  localparam int CZI_HI_POS = 38;
  localparam int CPI_POS    = 33;
  localparam int MUL_POS    = 32;
  localparam int RVI_POS    = 26;
  localparam int CZV_LO_POS = 8;
  localparam int CZV_HI_POS = 22;
  localparam int CPV_POS    = 17;
  localparam int RVV_POS    = 10;
  localparam int GMV_POS    = 4;
  localparam int GMI_POS    = 0;

  // boot phase: waits for the first image load
  typedef enum logic [1:0] {
    PH_BOOT = 2'b01,
    PH_RUN  = 2'b10
  } pic_phase_e;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [7:0]        code;
    logic [CNT_W-1:0]  count;
    logic [DATA_W-1:0] data;
  } pic_req_s;

  typedef struct packed {
    logic              valid;
    logic              refused;
    logic [CNT_W-1:0]  count;
    logic [DATA_W-1:0] data;
  } pic_resp_s;

  typedef struct packed {
    logic [ID_W-1:0]   maker;
    logic [ID_W-1:0]   model;
    logic [ID_W-1:0]   revn;
    logic [ID_W-1:0]   serial;
    logic [COMP_W-1:0] comp;
  } pic_image_s;

  typedef struct packed {
    logic [3:0] iloop_int_cap_code;
    logic [4:0] iloop_filter_cap_code;
    logic       iloop_int_cap_doubler;
    logic [5:0] iloop_gain_res_code;
    logic [3:0] vloop_int_cap_code;
    logic [4:0] vloop_filter_cap_code;
    logic [5:0] vloop_gain_res_code;
    logic [1:0] vloop_transcond_code;
    logic [1:0] iloop_transcond_code;
  } pic_comp_s;

  typedef struct packed {
    logic       status_byte_cml;
    logic [7:0] status_cml;
  } pic_fault_s;

endpackage

// ===== test/pic_host_model.sv
`timescale 1ns/1ns
module pic_host_model (
  // clock
  input  wire logic               clock,
  // block transfers toward the bank
  output pic_pkg::pic_req_s       req,
  input  wire pic_pkg::pic_resp_s resp
);
  import pic_pkg::*;
  // reserved compensation bits the host always clears
  localparam logic [47:0] RSV = 48'h0000000100cc;
  initial req = '0;
  // one block transfer; the answer stands one cycle after the request
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [2:0] n, input logic [47:0] d,
                      output pic_resp_s r);
    logic [47:0] m;
    m = (w && c == CMD_COMP) ? d & ~RSV : d;
    @(posedge clock);
    req <= '{1'b1, w, c, n, m};
    @(posedge clock);
    // released lines show the inverse, never a stale copy
    req <= '{1'b0, ~w, ~c, ~n, ~m};
    #1 r = resp;
  endtask
endmodule

// ===== test/pic_ident_comp_regs_assertions.sv
`timescale 1ns/1ns
module pic_ident_comp_regs_assertions #(
  parameter int SUM_W = 16
) (
  // clock and reset
  input wire logic               clock,
  input wire logic               rst,
  // command port and faults
  input wire pic_pkg::pic_req_s  req,
  input wire pic_pkg::pic_resp_s resp,
  input wire pic_pkg::pic_fault_s fault,
  // load, stores and loop
  input wire logic               nvm_load,
  input wire logic               conv_en,
  input wire pic_pkg::pic_image_s store_image,
  input wire logic [SUM_W-1:0]   stored_image_sum,
  input wire pic_pkg::pic_comp_s loop_comp
);
  import pic_pkg::*;
  logic        up;
  logic        ok;
  logic        ro;
  logic [47:0] d1;
  // nothing is accepted before the first image load
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      up <= 1'b0;
    end else if (nvm_load) begin
      up <= 1'b1;
    end
  end
  // last cycle's write data, so no $past of a slice is needed
  always_ff @(posedge clock) begin
    d1 <= req.data;
  end
  assign ok = up && !nvm_load && req.valid;
  assign ro = ok && req.write && (req.code == CMD_PART
              || req.code == CMD_SIREV);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_answer_next:
    assert property (req.valid |=> resp.valid) else $error("no answer");
  a_no_stray:
    assert property (!req.valid |=> !resp.valid) else $error("stray answer");
  a_maker_write:
    assert property (ok && req.write && req.code == CMD_MAKER
      && req.count == LEN_ID |=> store_image.maker == d1[23:0]
      && !resp.refused) else $error("maker store not written");
  a_ro_fault:
    assert property (ro |=> resp.refused && fault.status_byte_cml
      && fault.status_cml[CML_IVC_BIT]) else $error("no command fault");
  a_bad_len:
    assert property (ok && req.write && req.code == CMD_MAKER
      && req.count != LEN_ID |=> resp.refused && fault.status_byte_cml
      && fault.status_cml[CML_IVD_BIT] && $stable(store_image))
      else $error("short maker write taken");
  a_ro_no_store:
    assert property (ro |=> $stable(store_image)) else $error("ro changed");
  a_part_len:
    assert property (ok && !req.write && req.code == CMD_PART
      |=> resp.count == LEN_PART && !resp.refused) else $error("part len");
  a_rev_len:
    assert property (ok && !req.write && req.code == CMD_SIREV
      |=> resp.count == LEN_SIREV && !resp.refused) else $error("rev len");
  a_comp_apply:
    assert property (ok && req.write && req.code == CMD_COMP
      && req.count == LEN_COMP && !conv_en
      |=> loop_comp.iloop_transcond_code == d1[1:0]
      && loop_comp.vloop_transcond_code == d1[5:4])
      else $error("comp not applied");
  a_comp_hold:
    assert property (!nvm_load && (conv_en || !req.valid)
      |=> $stable(loop_comp)) else $error("loop comp moved");
  a_sum_serial:
    assert property ($changed(store_image.serial)
      |=> $changed(stored_image_sum)) else $error("sum ignores serial");
endmodule
bind pic_ident_comp_regs pic_ident_comp_regs_assertions #(
  .SUM_W (SUM_W)
) chk_u (
  .clock (clock), .rst (rst), .req (req), .resp (resp), .fault (fault),
  .nvm_load (nvm_load), .conv_en (conv_en), .store_image (store_image),
  .stored_image_sum (stored_image_sum), .loop_comp (loop_comp)
);

// ===== test/pic_ident_comp_regs_test.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("Error %s expected %h seen %h", n, e, g); \
  end \
end
module pic_ident_comp_regs_test;
  import pic_pkg::*;
  localparam logic [47:0] PC = 48'h3c5a96c3a55a; // arbitrary value
  logic        clock;
  logic        rst;
  logic        nvm_load;
  logic        strap_override_comp;
  logic        conv_en;
  logic [39:0] pin_comp;
  logic [15:0] s0;
  logic [39:0] cm;
  logic [7:0]  cd [4];
  pic_image_s  nvm_image;
  pic_image_s  ex;
  pic_image_s  store_image;
  pic_req_s    req;
  pic_resp_s   resp;
  pic_resp_s   r;
  pic_fault_s  fault;
  pic_comp_s   loop_comp;
  logic [15:0] stored_image_sum;
  int          checks = 0;
  int          fails = 0;
  pic_ident_comp_regs #(
    .PART_CODE (PC), .SIREV_MAJ (4'h2), .SIREV_MIN (4'h7),
    .SIREV_SUB (8'h31)
  ) dut_u (
    .clock (clock), .rst (rst), .req (req), .resp (resp), .fault (fault),
    .nvm_load (nvm_load), .nvm_image (nvm_image), .pin_comp (pin_comp),
    .strap_override_comp (strap_override_comp),
    .store_image (store_image), .stored_image_sum (stored_image_sum),
    .conv_en (conv_en), .loop_comp (loop_comp)
  );
  pic_host_model hm_u (.clock (clock), .req (req), .resp (resp));
  // expected loop fields, worked out from the bit map
  function automatic pic_comp_s fld(input logic [39:0] c);
    return {c[25:24], c[39:38], c[37:32], c[31:26], c[9:8], c[23:22],
            c[21:17], c[15:10], c[5:4], c[1:0]};
  endfunction
  function automatic logic [15:0] s3(input logic [23:0] v);
    return 16'(v[23:16]) + 16'(v[15:8]) + 16'(v[7:0]);
  endfunction
  task automatic op(input logic w, input logic [7:0] c, input logic [2:0] n,
                    input logic [47:0] d);
    hm_u.xfer(w, c, n, d, r);
  endtask
  // image load; restore and power-up look the same here
  task automatic load(input logic ov);
    @(posedge clock);
    nvm_image <= ex;
    strap_override_comp <= ov;
    nvm_load <= 1'b1;
    @(posedge clock);
    nvm_load <= 1'b0;
    #1;
  endtask
  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // the sequence needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    results();
  end
  initial begin
    rst = 1'b1;
    nvm_load = 1'b0;
    nvm_image = '0;
    pin_comp = 40'h3b0c0f1d21;
    strap_override_comp = 1'b0;
    conv_en = 1'b0;
    cd = '{CMD_MAKER, CMD_MODEL, CMD_REVN, CMD_SERIAL};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    op(1'b0, CMD_MAKER, 3'h0, '0);
    `CHK("boot refusal", 1'b1, r.refused)
    ex = '{24'h123456, 24'h6789ab, 24'hcdef01, 24'h234567, 40'h8a5f3c6d2e};
    load(1'b0);
    `CHK("loaded comp", fld(ex.comp), loop_comp)
    // each id store shows its load, then takes and returns a new value
    for (int i = 0; i < 4; i++) begin
      op(1'b0, cd[i], 3'h0, '0);
      `CHK("id count", LEN_ID, r.count)
      `CHK("id load", ex[135-24*i -: 24], r.data[23:0])
      s0 = stored_image_sum - s3(ex[135-24*i -: 24]);
      op(1'b1, cd[i], LEN_ID, {24'h0, ~ex[135-24*i -: 24]});
      `CHK("id write", 1'b0, r.refused)
      ex[135-24*i -: 24] = ~ex[135-24*i -: 24];
      op(1'b0, cd[i], 3'h0, '0);
      `CHK("id back", ex[135-24*i -: 24], r.data[23:0])
      if (i == 3) `CHK("sum", s0 + s3(ex.serial), stored_image_sum)
    end
    op(1'b0, CMD_PART, 3'h0, '0);
    `CHK("part count", LEN_PART, r.count)
    `CHK("part code", PC, r.data)
    op(1'b0, CMD_SIREV, 3'h0, '0);
    `CHK("rev count", LEN_SIREV, r.count)
    `CHK("rev value", 16'h2731, r.data[15:0])
    // writes to fixed codes: refused, fault raised, stores untouched
    for (int i = 0; i < 2; i++) begin
      op(1'b1, i ? CMD_SIREV : CMD_PART, i ? LEN_SIREV : LEN_PART, '1);
      `CHK("ro refused", 1'b1, r.refused)
      `CHK("ro fault", 9'h180, fault)
      `CHK("ro stores", ex, store_image)
    end
    // a short block write is bad data: refused, data fault, store kept
    op(1'b1, CMD_MAKER, 3'h2, 48'h0000000000ff);
    `CHK("len refused", 1'b1, r.refused)
    `CHK("len fault", 9'h140, fault)
    `CHK("len stores", ex, store_image)
    // a code not served here is refused and raises no fault
    op(1'b0, 8'h98, 3'h0, '0);
    `CHK("unknown refused", 1'b1, r.refused)
    `CHK("unknown fault", 9'h000, fault)
    op(1'b1, CMD_COMP, LEN_COMP, 48'h00ff5a5aa5ff);
    cm = 40'hff5a5aa533;
    `CHK("comp live", fld(cm), loop_comp)
    @(posedge clock);
    conv_en <= 1'b1;
    op(1'b1, CMD_COMP, LEN_COMP, 48'h001234567890);
    `CHK("comp held", fld(cm), loop_comp)
    op(1'b0, CMD_COMP, 3'h0, '0);
    `CHK("comp count", LEN_COMP, r.count)
    `CHK("comp back", 40'h1234567810, r.data[39:0])
    // stored value reaches the loop only on the next load
    ex.comp = 40'h1234567810;
    load(1'b0);
    `CHK("comp restored", fld(ex.comp), loop_comp)
    load(1'b1);
    `CHK("comp pins", fld(pin_comp), loop_comp)
    results();
  end
endmodule
